//--- ifv_consts.svh
`ifndef IFV_CONSTS_SVH
`define IFV_CONSTS_SVH
// *****************************************
// control register bit positions
// *****************************************
`define IFV_CTL_GLB_EN_BIT 7
`define IFV_CTL_PER_EN_BIT 6
`define IFV_CTL_TMR_EN_BIT 5
`define IFV_CTL_PINE_BIT   4
`define IFV_CTL_PCHE_BIT   3
`define IFV_CTL_TMR_FL_BIT 2
`define IFV_CTL_PINF_BIT   1
`define IFV_CTL_PCHF_BIT   0
`define IFV_OPT_EDGE_BIT   6
// *****************************************
// reset values and vector
// *****************************************
`define IFV_CTL_RESET      8'h00
`define IFV_PERIPH_RESET   8'h00
`define IFV_VECTOR_ADDR    13'h0004
// *****************************************
// timing: instruction cycles from pin event to vector
// *****************************************
`define IFV_LAT_MIN_CYC    3
`define IFV_LAT_MAX_CYC    4
`endif

//--- ifv_pkg.sv
package ifv_pkg;
   // software write to one 8-bit register: strobe and whole byte
   typedef struct packed {
      logic       wr;
      logic [7:0] data;
   } ifv_wr_t;
   // core sequencer events
   typedef struct packed {
      logic vector_taken;
      logic return_irq;
      logic sleep_enter;
   } ifv_core_t;
endpackage

//--- ifv_irq_logic.sv
`timescale 1ns/1ns
`include "ifv_consts.svh"
module ifv_irq_logic #(
   parameter int PERIPH_W = 8
) (
   input  wire logic                  i_sys_clk,
   input  wire logic                  i_rst,
   input  wire logic                  i_external_irq_pin,
   input  wire logic [3:0]            i_port_b_a_hi,
   input  wire logic                  i_timer0_wrap,
   input  wire logic [PERIPH_W-1:0]   i_periph_evt_a,
   input  wire logic [PERIPH_W-1:0]   i_periph_evt_b,
   input  wire logic                  i_pin_edge_select,
   input  wire ifv_pkg::ifv_wr_t      i_ctl_wr,
   input  wire ifv_pkg::ifv_wr_t      i_flag_a_wr,
   input  wire ifv_pkg::ifv_wr_t      i_flag_b_wr,
   input  wire ifv_pkg::ifv_wr_t      i_en_a_wr,
   input  wire ifv_pkg::ifv_wr_t      i_en_b_wr,
   input  wire ifv_pkg::ifv_core_t    i_core,
   input  wire logic [12:0]           i_return_pc,
   output logic [7:0]                 o_irq_control_reg,
   output logic [PERIPH_W-1:0]        o_periph_flag_reg_a,
   output logic [PERIPH_W-1:0]        o_periph_flag_reg_b,
   output logic [PERIPH_W-1:0]        o_periph_enable_reg_a,
   output logic [PERIPH_W-1:0]        o_periph_enable_reg_b,
   output logic                       o_irq_request,
   output logic                       o_wake,
   output logic                       o_asleep,
   output logic                       o_push,
   output logic [12:0]                o_push_pc,
   output logic                       o_load_pc,
   output logic [12:0]                o_pc_vector
);
   // *****************************************
   // pin synchronisers
   // *****************************************
   logic [2:0] pin_sync_reg;
   logic [2:0] pb_sync_reg [4];
   logic       pin_level_reg;
   logic [3:0] pb_level_reg;
   logic [3:0] pb_level_next;
   // three stages; a change counts once stages two and three agree
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         pin_sync_reg <= 3'h0;
      end else begin
         pin_sync_reg <= {pin_sync_reg[1:0], i_external_irq_pin};
      end
   end
   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_pb
         always_ff @(posedge i_sys_clk or posedge i_rst) begin
            if (i_rst) begin
               pb_sync_reg[g] <= 3'h0;
            end else begin
               pb_sync_reg[g] <= {pb_sync_reg[g][1:0], i_port_b_a_hi[g]};
            end
         end
         assign pb_level_next[g] = (pb_sync_reg[g][2] == pb_sync_reg[g][1]) ?
                                   pb_sync_reg[g][2] : pb_level_reg[g];
      end
   endgenerate
   // filtered levels and the edges derived from them
   logic pin_level_next;
   assign pin_level_next = (pin_sync_reg[2] == pin_sync_reg[1]) ?
                           pin_sync_reg[2] : pin_level_reg;
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         pin_level_reg <= 1'b0;
         pb_level_reg  <= 4'h0;
      end else begin
         pin_level_reg <= pin_level_next;
         pb_level_reg  <= pb_level_next;
      end
   end
   logic pin_edge;
   logic pb_change;
   // edge polarity picked by the edge select input
   assign pin_edge  = i_pin_edge_select ? (pin_level_next & ~pin_level_reg)
                                        : (~pin_level_next & pin_level_reg);
   assign pb_change = |(pb_level_next ^ pb_level_reg);
   // *****************************************
   // flag and enable registers
   // *****************************************
   logic [7:0] ctl_reg;
   logic [7:0] ctl_next;
   logic [PERIPH_W-1:0] fa_reg, fb_reg, ea_reg, eb_reg;
   // software write first, hardware sets layered over it so a set wins
   always_comb begin
      ctl_next = i_ctl_wr.wr ? i_ctl_wr.data : ctl_reg;
      if (i_core.vector_taken) begin
         ctl_next[`IFV_CTL_GLB_EN_BIT] = 1'b0;
      end
      if (i_core.return_irq) begin
         ctl_next[`IFV_CTL_GLB_EN_BIT] = 1'b1;
      end
      // sets ignore every enable; no clear on vectoring
      if (pin_edge) begin
         ctl_next[`IFV_CTL_PINF_BIT] = 1'b1;
      end
      if (i_timer0_wrap) begin
         ctl_next[`IFV_CTL_TMR_FL_BIT] = 1'b1;
      end
      if (pb_change) begin
         ctl_next[`IFV_CTL_PCHF_BIT] = 1'b1;
      end
   end
   // reset clears everything including the global enable
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         ctl_reg <= `IFV_CTL_RESET;
      end else begin
         ctl_reg <= ctl_next;
      end
   end
   // peripheral flags: set beats software clear
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         fa_reg <= PERIPH_W'(`IFV_PERIPH_RESET);
         fb_reg <= PERIPH_W'(`IFV_PERIPH_RESET);
      end else begin
         fa_reg <= (i_flag_a_wr.wr ? i_flag_a_wr.data[PERIPH_W-1:0] : fa_reg)
                   | i_periph_evt_a;
         fb_reg <= (i_flag_b_wr.wr ? i_flag_b_wr.data[PERIPH_W-1:0] : fb_reg)
                   | i_periph_evt_b;
      end
   end
   // peripheral enables, software owned
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         ea_reg <= PERIPH_W'(`IFV_PERIPH_RESET);
         eb_reg <= PERIPH_W'(`IFV_PERIPH_RESET);
      end else begin
         if (i_en_a_wr.wr) ea_reg <= i_en_a_wr.data[PERIPH_W-1:0];
         if (i_en_b_wr.wr) eb_reg <= i_en_b_wr.data[PERIPH_W-1:0];
      end
   end
   // *****************************************
   // request, wake and vectoring
   // *****************************************
   logic any_pending;
   logic sleep_reg;
   // core sources plus peripheral pairs under peripheral enable
   assign any_pending =
      (ctl_reg[`IFV_CTL_PINF_BIT] & ctl_reg[`IFV_CTL_PINE_BIT]) |
      (ctl_reg[`IFV_CTL_TMR_FL_BIT] & ctl_reg[`IFV_CTL_TMR_EN_BIT]) |
      (ctl_reg[`IFV_CTL_PCHF_BIT] & ctl_reg[`IFV_CTL_PCHE_BIT]) |
      (ctl_reg[`IFV_CTL_PER_EN_BIT] & |((fa_reg & ea_reg) | (fb_reg & eb_reg)));
   // request is combinational from registers so no instruction length
   // enters the path; latency is pin sync plus one flag edge
   assign o_irq_request = ctl_reg[`IFV_CTL_GLB_EN_BIT] & any_pending & ~sleep_reg;
   // sleep state; wake ignores the global enable
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         sleep_reg <= 1'b0;
      end else if (sleep_reg && any_pending) begin
         sleep_reg <= 1'b0;
      end else if (i_core.sleep_enter && !any_pending) begin
         sleep_reg <= 1'b1; // pending source makes sleep a no-op
      end
   end
   assign o_wake   = sleep_reg & any_pending;
   assign o_asleep = sleep_reg;
   // only the return pc is pushed; context is software's job
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         o_push    <= 1'b0;
         o_load_pc <= 1'b0;
         o_push_pc <= 13'h0000;
      end else begin
         o_push    <= i_core.vector_taken;
         o_load_pc <= i_core.vector_taken;
         if (i_core.vector_taken) o_push_pc <= i_return_pc;
      end
   end
   assign o_pc_vector           = `IFV_VECTOR_ADDR;
   assign o_irq_control_reg     = ctl_reg;
   assign o_periph_flag_reg_a   = fa_reg;
   assign o_periph_flag_reg_b   = fb_reg;
   assign o_periph_enable_reg_a = ea_reg;
   assign o_periph_enable_reg_b = eb_reg;
   // *****************************************
   // checks
   // *****************************************
   // an accepted vector with no return in the same cycle
   sequence s_accept;
      i_core.vector_taken && !i_core.return_irq;
   endsequence
   // what the core sees one cycle after acceptance
   sequence s_entry_out;
      !ctl_reg[`IFV_CTL_GLB_EN_BIT] ##0 o_push ##0 o_load_pc;
   endsequence
   // a rising pin change while software leaves the control register alone
   sequence s_pin_rise;
      $rose(i_external_irq_pin) && i_pin_edge_select && !i_ctl_wr.wr;
   endsequence
   // a falling pin change under falling edge select
   sequence s_pin_fall;
      $fell(i_external_irq_pin) && !i_pin_edge_select && !i_ctl_wr.wr;
   endsequence
   // three sync stages plus the flag edge, no software write meanwhile
   sequence s_quiet4;
      (!i_ctl_wr.wr)[*4];
   endsequence
   // reset release must leave the global enable low
   chk_reset_en_low: assert property (@(posedge i_sys_clk)
      $fell(i_rst) |-> !ctl_reg[`IFV_CTL_GLB_EN_BIT])
      else $error("global enable high after reset");
   // acceptance clears the enable and pulses push and load together
   chk_glb_clear_vec: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      s_accept |=> s_entry_out)
      else $error("global enable not cleared on vector");
   // the pushed pc is the one offered at acceptance
   chk_push_pc_taken: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      s_accept |=> (o_push_pc == $past(i_return_pc)))
      else $error("wrong return pc pushed");
   // push is a single-cycle pulse
   chk_push_one_cycle: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      o_push |=> !o_push)
      else $error("push held too long");
   chk_return_sets_en: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      i_core.return_irq |=> ctl_reg[`IFV_CTL_GLB_EN_BIT])
      else $error("return did not set global enable");
   chk_req_blocked: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      !ctl_reg[`IFV_CTL_GLB_EN_BIT] |-> !o_irq_request)
      else $error("request with global enable clear");
   // each pair written out on its own, not through the pending net
   chk_req_immediate: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (ctl_reg[`IFV_CTL_GLB_EN_BIT] && !sleep_reg &&
       ((|({ctl_reg[`IFV_CTL_TMR_EN_BIT], ctl_reg[`IFV_CTL_PINE_BIT],
            ctl_reg[`IFV_CTL_PCHE_BIT]} & ctl_reg[2:0])) ||
        (ctl_reg[`IFV_CTL_PER_EN_BIT] && (|(fa_reg & ea_reg) || |(fb_reg & eb_reg)))))
      |-> o_irq_request)
      else $error("request not raised");
   // no request without a live flag-enable pair
   chk_req_has_source: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      o_irq_request |-> ((|({ctl_reg[`IFV_CTL_TMR_EN_BIT], ctl_reg[`IFV_CTL_PINE_BIT],
            ctl_reg[`IFV_CTL_PCHE_BIT]} & ctl_reg[2:0])) ||
        (ctl_reg[`IFV_CTL_PER_EN_BIT] && (|(fa_reg & ea_reg) || |(fb_reg & eb_reg)))))
      else $error("request without source");
   chk_no_req_asleep: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      sleep_reg |-> !o_irq_request)
      else $error("request while asleep");
   chk_timer_flag_set: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      i_timer0_wrap |=> ctl_reg[`IFV_CTL_TMR_FL_BIT])
      else $error("timer flag lost");
   chk_pin_flag_set: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      pin_edge |=> ctl_reg[`IFV_CTL_PINF_BIT])
      else $error("pin flag lost");
   chk_pb_flag_set: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      pb_change |=> ctl_reg[`IFV_CTL_PCHF_BIT])
      else $error("port change flag lost");
   chk_flag_kept_vec: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (s_accept and !i_ctl_wr.wr and ctl_reg[`IFV_CTL_PINF_BIT])
      |=> ctl_reg[`IFV_CTL_PINF_BIT])
      else $error("flag cleared by vectoring");
   // every pulsed bit must land, even against a software clear
   chk_periph_set: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      |i_periph_evt_a |=> ((fa_reg & $past(i_periph_evt_a)) == $past(i_periph_evt_a)))
      else $error("peripheral flag lost");
   chk_periph_b_set: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      |i_periph_evt_b |=> ((fb_reg & $past(i_periph_evt_b)) == $past(i_periph_evt_b)))
      else $error("peripheral flag b lost");
   // sync takes three edges, the flag one more
   chk_pin_latency: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      s_pin_rise ##1 s_quiet4 |-> ctl_reg[`IFV_CTL_PINF_BIT])
      else $error("pin flag late");
   chk_pin_fall: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      s_pin_fall ##1 (s_quiet4 and (!i_pin_edge_select)[*4])
      |-> ctl_reg[`IFV_CTL_PINF_BIT])
      else $error("falling edge missed");
   // sleep request with an enabled source pending must not stick
   chk_sleep_noop: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (i_core.sleep_enter && any_pending) |=> !sleep_reg)
      else $error("slept with source pending");
   chk_wake_no_gie: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (sleep_reg && any_pending) |=> !sleep_reg)
      else $error("no wake on pending source");
endmodule

//--- ifv_core_model.sv
`timescale 1ns/1ns
// *****************************************
// core sequencer stand-in
// *****************************************
module ifv_core_model (
   input  wire logic          i_sys_clk,
   input  wire logic          i_rst,
   input  wire logic          i_irq_request,
   input  wire logic          i_do_ret,
   input  wire logic          i_do_sleep,
   output ifv_pkg::ifv_core_t o_core
);
   // answers a request at once, one pulse; never twice in a row, since the
   // global enable only drops one edge after the pulse is taken
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         o_core <= '0;
      end else begin
         o_core.vector_taken <= i_irq_request & !o_core.vector_taken;
         o_core.return_irq   <= i_do_ret;
         o_core.sleep_enter  <= i_do_sleep;
      end
   end
endmodule

//--- ifv_irq_logic_tb_top.sv
`timescale 1ns/1ns
// *****************************************
// bench top
// *****************************************
module ifv_irq_logic_tb_top;
   logic               i_sys_clk = 1'b0;
   logic               i_rst = 1'b1;
   logic               pin = 1'b0, tw = 1'b0, es = 1'b1, ret = 1'b0, slp = 1'b0;
   logic [3:0]         pb = 4'h0;
   logic [7:0]         ea = 8'h00, eb = 8'h00, ctl, fa, fb, na, nb;
   logic [12:0]        rpc = 13'h0000, ppc, vec;
   logic               req, wake, asleep, push, load;
   ifv_pkg::ifv_wr_t   wb [5] = '{default: '0};
   ifv_pkg::ifv_core_t core;
   int                 error_cnt = 0, compares = 0, seed = 83, n, p, pushes = 0;

   ifv_irq_logic u_ifv_irq_logic (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
      .i_external_irq_pin(pin), .i_port_b_a_hi(pb), .i_timer0_wrap(tw),
      .i_periph_evt_a(ea), .i_periph_evt_b(eb), .i_pin_edge_select(es),
      .i_ctl_wr(wb[0]), .i_flag_a_wr(wb[1]), .i_flag_b_wr(wb[2]), .i_en_a_wr(wb[3]),
      .i_en_b_wr(wb[4]), .i_core(core), .i_return_pc(rpc), .o_irq_control_reg(ctl),
      .o_periph_flag_reg_a(fa), .o_periph_flag_reg_b(fb), .o_periph_enable_reg_a(na),
      .o_periph_enable_reg_b(nb), .o_irq_request(req), .o_wake(wake), .o_asleep(asleep),
      .o_push(push), .o_push_pc(ppc), .o_load_pc(load), .o_pc_vector(vec));
   ifv_core_model u_ifv_core_model (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
      .i_irq_request(req), .i_do_ret(ret), .i_do_sleep(slp), .o_core(core));

   // clock and vector-entry counter; push and load must come together
   always #5 i_sys_clk = ~i_sys_clk;
   always @(posedge i_sys_clk) if (push === 1'b1 && load === 1'b1) pushes <= pushes + 1;

   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // whole-byte write, strobe up for one cycle
   task automatic wr(input int k, input logic [7:0] d);
      @(negedge i_sys_clk) wb[k] = '{1'b1, d};
      @(negedge i_sys_clk) wb[k].wr = 1'b0;
   endtask
   task automatic report_and_stop;
      $display("errors %0d compares %0d", error_cnt, compares);
      if (error_cnt == 0 && compares > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   // watchdog, far beyond the hundred or so cycles the run needs
   initial begin
      #100000;
      error_cnt++;
      report_and_stop();
   end

   initial begin
      repeat (8) @(posedge i_sys_clk);
      @(negedge i_sys_clk) i_rst = 1'b0;
      chk("ctl", ctl, 8'h00);
      chk("vec", vec, 13'h0004);
      // timer wrap with every enable off: flag set, nothing requested
      rpc = 13'($random(seed));
      tw = 1'b1;
      @(negedge i_sys_clk) tw = 1'b0;
      chk("ctl", ctl, 8'h04);
      chk("req", req, 1'b0);
      // global enable on: vector, enable cleared, flag kept, pc pushed
      wr(0, 8'hA4);
      repeat (4) @(negedge i_sys_clk);
      chk("push", pushes, 1);
      chk("ppc", ppc, rpc);
      chk("ctl", ctl, 8'h24);
      // return sets the enable again; the uncleared flag re-enters
      ret = 1'b1;
      @(negedge i_sys_clk) ret = 1'b0;
      repeat (4) @(negedge i_sys_clk);
      chk("push", pushes, 2);
      chk("ctl", ctl, 8'h24);
      // one random peripheral bit in each bank, peripheral gate off then on
      for (int k = 0; k < 2; k++) begin
         n = $unsigned($random(seed)) % 8;
         wr(0, 8'h00);
         wr(3 + k, 8'h01 << n);
         chk("pen", k ? nb : na, 8'h01 << n);
         @(negedge i_sys_clk) {eb, ea} = 16'h0001 << (n + 8 * k);
         @(negedge i_sys_clk) {eb, ea} = 16'h0000;
         chk("pflag", k ? fb : fa, 8'h01 << n);
         wr(0, 8'h80);
         chk("req", req, 1'b0);
         p = pushes;
         wr(0, 8'hC0);
         repeat (3) @(negedge i_sys_clk);
         chk("push", pushes, p + 1);
         chk("ctl", ctl, 8'h40);
         wr(1 + k, 8'h00);
      end
      wr(0, 8'h00);
      // pin edges for both selects: latency of the valid one, wrong one ignored
      for (int e = 0; e < 2; e++) begin
         es = e[0];
         pin = !e[0];
         repeat (6) @(negedge i_sys_clk);
         wr(0, 8'h00);
         pin = e[0];
         n = 0;
         while (ctl[1] !== 1'b1 && n < 10) begin
            @(negedge i_sys_clk);
            n++;
         end
         chk("lat", n >= 3 && n <= 5, 1'b1);
         wr(0, 8'h00);
         pin = !e[0];
         repeat (6) @(negedge i_sys_clk);
         chk("pinf", ctl[1], 1'b0);
      end
      // one random port-b bit toggles
      pb = pb ^ (4'h1 << ($unsigned($random(seed)) % 4));
      repeat (6) @(negedge i_sys_clk);
      chk("pchf", ctl[0], 1'b1);
      // sleep with pin enable only, global enable off: pin edge wakes
      wr(0, 8'h10);
      slp = 1'b1;
      @(negedge i_sys_clk) slp = 1'b0;
      repeat (3) @(negedge i_sys_clk);
      chk("asleep", asleep, 1'b1);
      pin = 1'b1;
      // wake stands for one cycle only, so poll for it
      n = 0;
      while (wake !== 1'b1 && n < 10) begin
         @(negedge i_sys_clk);
         n++;
      end
      chk("wake", wake, 1'b1);
      chk("req", req, 1'b0);
      @(negedge i_sys_clk);
      chk("asleep", asleep, 1'b0);
      report_and_stop();
   end
endmodule
